// file: verilog/pcp_top.sv
// Fetch pointer sequencing, bank/location pointers and table high holder.
// Assumes the decoder presents one instruction class per cycle on cmd.
//
// Operation
// R1 - Fetch pointer: 6-bit upper, 8-bit lower
// R2 - Advance by one per executed instruction
// R3 - Branch or call loads all fourteen bits
// R4 - Five skip instructions advance by two
// R5 - Bit test skips when bit matches condition
// R6 - Compare skips when accumulator equals operand
// R7 - Increment skip on wrap 0xFF to 0x00
// R8 - Decrement skip on wrap 0x00 to 0xFF
// R9 - Lower byte add overflow increments upper
// R10 - Lower byte borrow leaves upper unchanged
// R11 - Bank and location pointers: 8-bit registers
// R12 - Bank and location form indirect RAM address
// R13 - Bank and location address ROM table read
// R14 - Table read: high to holder, low out
// R15 - Table high holder: 8-bit working register
// R16 - Reset clears fetch pointer to zero
// R17 - Move to lower byte keeps upper byte
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pcp_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [pcp_pkg::ADR_W-1:0] paddr,
  input  wire logic [pcp_pkg::DAT_W-1:0] pwdata,
  output var  logic [pcp_pkg::DAT_W-1:0] prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  input  wire pcp_pkg::pcp_cmd_t        cmd,
  output var  logic [pcp_pkg::FP_W-1:0] fetch_pointer,
  output var  logic [15:0]              indirect_ram_port,
  output var  logic [15:0]              rom_table_addr,
  output var  logic [pcp_pkg::LO_W-1:0] primary_operand_reg,
  output var  logic                     acc_load,
  output var  logic                     skip_taken
);
  typedef struct packed {
    logic [pcp_pkg::UP_W-1:0]  fp_upper;
    logic [pcp_pkg::LO_W-1:0]  fp_lower;
    logic [pcp_pkg::LO_W-1:0]  acc_out;
    logic                      acc_ld;
    logic                      skip;
    logic [15:0]               ram_addr;
    logic [15:0]               rom_addr;
    pcp_pkg::pcp_bus_st_t      bus;
    logic [pcp_pkg::DAT_W-1:0] rdata;
    logic                      ready;
    logic                      err;
    logic                      rd_mem;
  } pcp_st_t;

  pcp_st_t st_reg;
  pcp_st_t st_next;

  logic                     mem_we;
  logic [1:0]               mem_waddr;
  logic [pcp_pkg::LO_W-1:0] mem_wdata;
  logic [1:0]               mem_raddr;
  logic [pcp_pkg::LO_W-1:0] mem_rdata;
  logic [pcp_pkg::LO_W-1:0] holder_q;
  logic [pcp_pkg::LO_W-1:0] location_q;
  logic [pcp_pkg::LO_W-1:0] bank_q;

  // Byte-wide 9-bit sum, carry in top bit
  function automatic logic [pcp_pkg::LO_W:0] add9(
    input logic [pcp_pkg::LO_W-1:0] a,
    input logic [pcp_pkg::LO_W-1:0] b
  );
    add9 = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic [1:0] slot_of(
    input logic [pcp_pkg::ADR_W-1:0] a
  );
    if (a == pcp_pkg::ADR_TABLE_HIGH) begin
      slot_of = 2'h0;
    end else if (a == pcp_pkg::ADR_LOCATION) begin
      slot_of = 2'h1;
    end else if (a == pcp_pkg::ADR_BANK) begin
      slot_of = 2'h2;
    end else begin
      slot_of = 2'h3;
    end
  endfunction

  pcp_byte_reg u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata),
    .word0   (holder_q),
    .word1   (location_q),
    .word2   (bank_q)
  );

  logic                          setup;
  logic                          access;
  logic [pcp_pkg::FP_W-1:0]      fp_cur;
  logic [pcp_pkg::LO_W:0]        lo_sum;
  logic [pcp_pkg::LO_W-1:0]      lo_diff;
  logic                          do_skip;

  always_comb begin
    st_next   = st_reg;
    fp_cur    = {st_reg.fp_upper, st_reg.fp_lower}; // see R1
    setup     = psel && !penable;
    access    = psel && penable;
    mem_we    = 1'b0;
    mem_waddr = 2'h3;
    mem_wdata = pcp_pkg::BYTE_ZERO;
    mem_raddr = slot_of(paddr);
    lo_sum    = add9(st_reg.fp_lower, cmd.operand_a);
    lo_diff   = st_reg.fp_lower - cmd.operand_a;
    do_skip   = 1'b0;
    st_next.acc_ld = 1'b0;
    st_next.skip   = 1'b0;

    if (cmd.valid) begin
      case (cmd.op)
        pcp_pkg::PCP_OP_STEP: begin
          fp_cur = fp_cur + pcp_pkg::STEP_ONE; // see R2
        end
        pcp_pkg::PCP_OP_BRANCH: begin
          fp_cur = cmd.target; // see R3
        end
        pcp_pkg::PCP_OP_CMP_SKIP: begin
          do_skip = (cmd.operand_a == cmd.operand_b); // see R6
        end
        pcp_pkg::PCP_OP_INC_SKIP: begin
          do_skip = (cmd.operand_a == pcp_pkg::BYTE_MAX); // see R7
        end
        pcp_pkg::PCP_OP_DEC_SKIP: begin
          do_skip = (cmd.operand_a == pcp_pkg::BYTE_ZERO); // see R8
        end
        pcp_pkg::PCP_OP_BCLR_SKIP: begin
          do_skip = !cmd.tested_bit; // see R5
        end
        pcp_pkg::PCP_OP_BSET_SKIP: begin
          do_skip = cmd.tested_bit; // see R5
        end
        pcp_pkg::PCP_OP_ADD_LO: begin
          // Carry ripples into the upper byte for jump tables
          fp_cur = {st_reg.fp_upper + (lo_sum[pcp_pkg::LO_W] ?
                    pcp_pkg::UP_ONE : '0), lo_sum[pcp_pkg::LO_W-1:0]}; // see R9
        end
        pcp_pkg::PCP_OP_SUB_LO: begin
          fp_cur = {st_reg.fp_upper, lo_diff}; // see R10
        end
        pcp_pkg::PCP_OP_MOVE_LO: begin
          fp_cur = {st_reg.fp_upper, cmd.operand_a}; // see R17
        end
        pcp_pkg::PCP_OP_TABLE_RD: begin
          // High byte to holder, low byte to the accumulator
          mem_we    = 1'b1;
          mem_waddr = 2'h0;
          mem_wdata = cmd.rom_word[15:8]; // see R14
          st_next.acc_out = cmd.rom_word[7:0]; // see R14
          st_next.acc_ld  = 1'b1;
          fp_cur = fp_cur + pcp_pkg::STEP_ONE;
        end
        default: begin
          fp_cur = fp_cur;
        end
      endcase
      if (cmd.op inside {pcp_pkg::PCP_OP_CMP_SKIP, pcp_pkg::PCP_OP_INC_SKIP,
                         pcp_pkg::PCP_OP_DEC_SKIP, pcp_pkg::PCP_OP_BCLR_SKIP,
                         pcp_pkg::PCP_OP_BSET_SKIP}) begin
        fp_cur = fp_cur + (do_skip ? pcp_pkg::STEP_SKIP
                                   : pcp_pkg::STEP_ONE); // see R4
        st_next.skip = do_skip;
      end
    end

    // APB slave, zero wait on the first access cycle; core writes win
    st_next.ready = 1'b0;
    st_next.err   = 1'b0;
    st_next.bus   = pcp_pkg::PCP_BUS_IDLE;
    if (setup) begin
      st_next.ready = 1'b1;
      st_next.bus   = pcp_pkg::PCP_BUS_DONE;
      st_next.rdata = '0;
      st_next.rd_mem = 1'b0;
      if (slot_of(paddr) != 2'h3) begin
        st_next.rd_mem = !pwrite;
      end else if (paddr == pcp_pkg::ADR_FETCH) begin
        st_next.rdata = {{(pcp_pkg::DAT_W-pcp_pkg::FP_W){1'b0}}, fp_cur};
      end else if (paddr == pcp_pkg::ADR_FETCH_LO) begin
        st_next.rdata = {{(pcp_pkg::DAT_W-pcp_pkg::LO_W){1'b0}},
                         fp_cur[pcp_pkg::LO_W-1:0]};
      end else if (paddr == pcp_pkg::ADR_ROM_ADDR) begin
        st_next.rdata = {16'h0000, bank_q, location_q}; // see R13
      end else begin
        st_next.err = 1'b1;
      end
    end
    if (access && st_reg.bus == pcp_pkg::PCP_BUS_DONE && pwrite &&
        !mem_we && slot_of(paddr) != 2'h3) begin
      mem_we    = 1'b1; // see R11
      mem_waddr = slot_of(paddr);
      mem_wdata = pwdata[pcp_pkg::LO_W-1:0]; // see R15
    end
    if (access && st_reg.bus == pcp_pkg::PCP_BUS_DONE && pwrite &&
        !cmd.valid) begin
      if (paddr == pcp_pkg::ADR_FETCH) begin
        fp_cur = pwdata[pcp_pkg::FP_W-1:0];
      end else if (paddr == pcp_pkg::ADR_FETCH_LO) begin
        fp_cur = {st_reg.fp_upper, pwdata[pcp_pkg::LO_W-1:0]}; // see R17
      end
    end

    st_next.fp_upper = fp_cur[pcp_pkg::FP_W-1:pcp_pkg::LO_W];
    st_next.fp_lower = fp_cur[pcp_pkg::LO_W-1:0];
    st_next.ram_addr = {bank_q, location_q}; // see R12
    st_next.rom_addr = {bank_q, location_q}; // see R13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0; // see R16
    end else begin
      st_reg <= st_next;
    end
  end

  assign fetch_pointer       = {st_reg.fp_upper, st_reg.fp_lower};
  assign indirect_ram_port   = st_reg.ram_addr;
  assign rom_table_addr      = st_reg.rom_addr;
  assign primary_operand_reg = st_reg.acc_out;
  assign acc_load            = st_reg.acc_ld;
  assign skip_taken          = st_reg.skip;
  assign prdata  = st_reg.rd_mem ?
                   {{(pcp_pkg::DAT_W-pcp_pkg::LO_W){1'b0}}, mem_rdata}
                   : st_reg.rdata;
  assign pready  = st_reg.ready;
  assign pslverr = st_reg.err;
endmodule
`default_nettype wire

// file: verilog/pcp_pkg.sv
// Constants, register map and carrier types of the fetch pointer block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package pcp_pkg;
  localparam int unsigned FP_W   = 14;
  localparam int unsigned UP_W   = 6;
  localparam int unsigned LO_W   = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned ADR_W  = 12;
  // Printed offsets are not multiples of four: they are indices
  localparam logic [9:0] IDX_TABLE_HIGH = 10'h082;
  localparam logic [9:0] IDX_LOCATION   = 10'h083;
  localparam logic [9:0] IDX_BANK       = 10'h084;
  localparam logic [9:0] IDX_FETCH      = 10'h085;
  localparam logic [9:0] IDX_FETCH_LO   = 10'h086;
  localparam logic [9:0] IDX_ROM_ADDR   = 10'h087;
  localparam logic [ADR_W-1:0] ADR_TABLE_HIGH = {IDX_TABLE_HIGH, 2'b00};
  localparam logic [ADR_W-1:0] ADR_LOCATION   = {IDX_LOCATION, 2'b00};
  localparam logic [ADR_W-1:0] ADR_BANK       = {IDX_BANK, 2'b00};
  localparam logic [ADR_W-1:0] ADR_FETCH      = {IDX_FETCH, 2'b00};
  localparam logic [ADR_W-1:0] ADR_FETCH_LO   = {IDX_FETCH_LO, 2'b00};
  localparam logic [ADR_W-1:0] ADR_ROM_ADDR   = {IDX_ROM_ADDR, 2'b00};
  localparam logic [FP_W-1:0] FP_RESET   = 14'h0000;
  localparam logic [LO_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [LO_W-1:0] BYTE_MAX   = 8'hff;
  localparam logic [LO_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [FP_W-1:0] STEP_ONE   = 14'h0001;
  localparam logic [FP_W-1:0] STEP_SKIP  = 14'h0002;
  localparam logic [UP_W-1:0] UP_ONE     = 6'h01;

  // Instruction classes presented by the decoder
  typedef enum logic [3:0] {
    PCP_OP_NONE     = 4'b0000,
    PCP_OP_STEP     = 4'b0001,
    PCP_OP_BRANCH   = 4'b0010,
    PCP_OP_CMP_SKIP = 4'b0011,
    PCP_OP_INC_SKIP = 4'b0100,
    PCP_OP_DEC_SKIP = 4'b0101,
    PCP_OP_BCLR_SKIP = 4'b0110,
    PCP_OP_BSET_SKIP = 4'b0111,
    PCP_OP_ADD_LO   = 4'b1000,
    PCP_OP_SUB_LO   = 4'b1001,
    PCP_OP_MOVE_LO  = 4'b1010,
    PCP_OP_TABLE_RD = 4'b1011
  } pcp_op_t;

  typedef struct packed {
    logic            valid;
    pcp_op_t         op;
    logic [FP_W-1:0] target;
    logic [LO_W-1:0] operand_a;
    logic [LO_W-1:0] operand_b;
    logic            tested_bit;
    logic [15:0]     rom_word;
  } pcp_cmd_t;

  typedef struct packed {
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [ADR_W-1:0] paddr;
    logic [DAT_W-1:0] pwdata;
  } pcp_apb_req_t;

  typedef enum logic [1:0] {
    PCP_BUS_IDLE = 2'b00,
    PCP_BUS_DONE = 2'b01
  } pcp_bus_st_t;
endpackage

// file: verilog/pcp_byte_reg.sv
// Small register file holding the 8-bit table high holder and the two 8-bit pointer registers.
// Assumes one write port and registered read data, one cycle latency.
`timescale 1ns/100ps
`default_nettype none
module pcp_byte_reg (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   we,
  input  wire logic [1:0]             waddr,
  input  wire logic [pcp_pkg::LO_W-1:0] wdata,
  input  wire logic [1:0]             raddr,
  output var  logic [pcp_pkg::LO_W-1:0] rdata,
  output var  logic [pcp_pkg::LO_W-1:0] word0,
  output var  logic [pcp_pkg::LO_W-1:0] word1,
  output var  logic [pcp_pkg::LO_W-1:0] word2
);
  typedef struct packed {
    logic [2:0][pcp_pkg::LO_W-1:0] mem;
    logic [pcp_pkg::LO_W-1:0]      rd;
  } pcp_mem_st_t;

  pcp_mem_st_t st_reg;
  pcp_mem_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (we && waddr != 2'h3) begin
      st_next.mem[waddr] = wdata;
    end
    if (raddr == 2'h3) begin
      st_next.rd = pcp_pkg::BYTE_ZERO;
    end else begin
      st_next.rd = st_reg.mem[raddr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rd;
  assign word0 = st_reg.mem[0];
  assign word1 = st_reg.mem[1];
  assign word2 = st_reg.mem[2];
endmodule
`default_nettype wire

// file: test/pcp_properties.sv
// Concurrent checks on the fetch pointer block ports.
// Assumes binding to pcp_top; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pcp_properties (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire pcp_pkg::pcp_cmd_t            cmd,
  input wire logic [pcp_pkg::FP_W-1:0]     fetch_pointer,
  input wire logic [15:0]                  indirect_ram_port,
  input wire logic [15:0]                  rom_table_addr,
  input wire logic [pcp_pkg::LO_W-1:0]     primary_operand_reg,
  input wire logic                         acc_load,
  input wire logic                         skip_taken
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pcp_pkg::pcp_op_t op;
  logic [8:0]       lo_sum;
  logic [7:0]       lo_dif;
  logic [5:0]       fp_up;
  logic             cond;
  logic             is_skip;
  // Invalid slots read as no-op so stale fields never fire a check
  assign op = cmd.valid ? cmd.op : pcp_pkg::PCP_OP_NONE;
  assign lo_sum = {1'b0, fetch_pointer[7:0]} + {1'b0, cmd.operand_a};
  assign lo_dif = fetch_pointer[7:0] - cmd.operand_a;
  assign fp_up = fetch_pointer[13:8];
  assign is_skip = op inside {[pcp_pkg::PCP_OP_CMP_SKIP:pcp_pkg::PCP_OP_BSET_SKIP]};
  always_comb begin
    case (op)
      pcp_pkg::PCP_OP_CMP_SKIP:  cond = cmd.operand_a == cmd.operand_b;
      pcp_pkg::PCP_OP_INC_SKIP:  cond = cmd.operand_a == 8'hff;
      pcp_pkg::PCP_OP_DEC_SKIP:  cond = cmd.operand_a == 8'h00;
      pcp_pkg::PCP_OP_BCLR_SKIP: cond = !cmd.tested_bit;
      pcp_pkg::PCP_OP_BSET_SKIP: cond = cmd.tested_bit;
      default:                   cond = 1'b0;
    endcase
  end
  sequence s_skip_req;
    is_skip && cond;
  endsequence
  sequence s_skip_done;
    skip_taken && fetch_pointer == $past(fetch_pointer) + 14'h0002;
  endsequence
  a_reset_fp_zero: assert property ($rose(presetn) |-> fetch_pointer == 14'h0000) else $error("fetch pointer not zero after reset");
  a_step_plus_one: assert property (op == pcp_pkg::PCP_OP_STEP |=> fetch_pointer == $past(fetch_pointer) + 14'h0001) else $error("step did not add one");
  a_branch_load_all: assert property (op == pcp_pkg::PCP_OP_BRANCH |=> fetch_pointer == $past(cmd.target)) else $error("branch target not loaded");
  a_skip_by_two: assert property (s_skip_req |=> s_skip_done) else $error("true skip did not add two");
  a_no_skip_step: assert property (is_skip && !cond |=> !skip_taken && fetch_pointer == $past(fetch_pointer) + 14'h0001) else $error("false skip misstepped");
  a_add_carry_up: assert property (op == pcp_pkg::PCP_OP_ADD_LO |=> fetch_pointer == {$past(fp_up) + 6'($past(lo_sum[8])), $past(lo_sum[7:0])}) else $error("lower add carry wrong");
  a_sub_keep_upper: assert property (op == pcp_pkg::PCP_OP_SUB_LO |=> fetch_pointer == {$past(fp_up), $past(lo_dif)}) else $error("borrow touched upper");
  a_move_keep_upper: assert property (op == pcp_pkg::PCP_OP_MOVE_LO |=> fetch_pointer == {$past(fp_up), $past(cmd.operand_a)}) else $error("move touched upper");
  a_table_low_acc: assert property (op == pcp_pkg::PCP_OP_TABLE_RD |=> acc_load && primary_operand_reg == $past(cmd.rom_word[7:0])) else $error("table low byte lost");
  a_ram_addr_pair: assert property (indirect_ram_port == rom_table_addr) else $error("ram and rom address differ");
  // Pulses must trace back to their cause, not just appear when expected
  a_skip_only_true: assert property (
    skip_taken |-> $past(is_skip && cond))
    else $error("skip pulse without true skip");
  a_acc_only_table: assert property (
    acc_load |-> $past(op) == pcp_pkg::PCP_OP_TABLE_RD)
    else $error("acc load without table read");
  a_table_step_one: assert property (
    op == pcp_pkg::PCP_OP_TABLE_RD |=>
      fetch_pointer == $past(fetch_pointer) + 14'h0001)
    else $error("table read did not step");
endmodule
bind pcp_top pcp_properties u_pcp_properties (.pclk, .presetn, .cmd, .fetch_pointer,
  .indirect_ram_port, .rom_table_addr, .primary_operand_reg, .acc_load, .skip_taken);
`default_nettype wire

// file: test/pcp_decoder_model.sv
// Decoder model: presents one instruction class on cmd when asked.
// Assumes pcp_top samples cmd at the rising edge of pclk.
`timescale 1ns/100ps
`default_nettype none
module pcp_decoder_model (
  input  wire logic            pclk,
  output var  pcp_pkg::pcp_cmd_t cmd
);
  initial cmd = '0;
  // Fields are scrambled once released, so a stale word cannot pass as valid
  task automatic issue(input pcp_pkg::pcp_cmd_t c);
    pcp_pkg::pcp_cmd_t t;
    t = ~c;
    t.valid = 1'b0;
    c.valid = 1'b1;
    @(posedge pclk);
    cmd <= c;
    @(posedge pclk);
    cmd <= t;
  endtask
endmodule
`default_nettype wire

// file: test/test_program_counter_and_pointers.sv
// Self-checking bench for pcp_top: APB register access and fetch sequencing.
// Assumes pcp_decoder_model drives cmd and pcp_properties is bound in.
`timescale 1ns/100ps
`default_nettype none
module test_program_counter_and_pointers;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, acc_load, skip_taken, err;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd, wd, r;
  logic [13:0]       fetch_pointer, fp;
  logic [15:0]       indirect_ram_port, rom_table_addr;
  logic [7:0]        primary_operand_reg;
  logic [7:0]        v [3];
  logic [11:0]       adr [3];
  pcp_pkg::pcp_cmd_t cmd, c;
  int                n_errors, samples_checked, seed;
  pcp_top u_pcp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmd, .fetch_pointer,
    .indirect_ram_port, .rom_table_addr, .primary_operand_reg, .acc_load,
    .skip_taken);
  pcp_decoder_model u_pcp_decoder_model (.pclk, .cmd);
  always #5 pclk = ~pclk;
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // Zero-wait slave is expected, but the wait is bounded, not assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready stands high
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic skp(input pcp_pkg::pcp_cmd_t x);
    case (x.op)
      pcp_pkg::PCP_OP_CMP_SKIP:  return x.operand_a == x.operand_b;
      pcp_pkg::PCP_OP_INC_SKIP:  return x.operand_a == 8'hff;
      pcp_pkg::PCP_OP_DEC_SKIP:  return x.operand_a == 8'h00;
      pcp_pkg::PCP_OP_BCLR_SKIP: return !x.tested_bit;
      pcp_pkg::PCP_OP_BSET_SKIP: return x.tested_bit;
      default:                   return 1'b0;
    endcase
  endfunction
  function automatic logic [13:0] nxt(input logic [13:0] f, input pcp_pkg::pcp_cmd_t x);
    logic [8:0] s;
    s = {1'b0, f[7:0]} + {1'b0, x.operand_a};
    case (x.op)
      pcp_pkg::PCP_OP_BRANCH:  return x.target;
      pcp_pkg::PCP_OP_ADD_LO:  return {f[13:8] + {5'h00, s[8]}, s[7:0]};
      pcp_pkg::PCP_OP_SUB_LO:  return {f[13:8], f[7:0] - x.operand_a};
      pcp_pkg::PCP_OP_MOVE_LO: return {f[13:8], x.operand_a};
      default:                 return f + (skp(x) ? 14'h0002 : 14'h0001);
    endcase
  endfunction
  task automatic run_op(input pcp_pkg::pcp_cmd_t x);
    logic [13:0] e;
    logic        t;
    e = nxt(fp, x);
    t = x.op == pcp_pkg::PCP_OP_TABLE_RD;
    u_pcp_decoder_model.issue(x);
    @(negedge pclk);
    chk("fetch_pointer", {18'h0, e}, {18'h0, fetch_pointer});
    chk("skip_taken", {31'h0, skp(x)}, {31'h0, skip_taken});
    chk("acc_load", {31'h0, t}, {31'h0, acc_load});
    fp = e;
    if (t) begin
      chk("operand_reg", {24'h0, x.rom_word[7:0]}, {24'h0, primary_operand_reg});
      apb(1'b0, pcp_pkg::ADR_TABLE_HIGH, 32'h0);
      chk("holder", {24'h0, x.rom_word[15:8]}, rd);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h186c1466;
    adr = '{pcp_pkg::ADR_TABLE_HIGH, pcp_pkg::ADR_LOCATION, pcp_pkg::ADR_BANK};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pcp_pkg::ADR_FETCH, 32'h0);
    chk("fetch_reset", 32'h0, rd);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, adr[i], 32'h0);
      chk("byte_reset", 32'h0, rd);
      wd = $random(seed);
      apb(1'b1, adr[i], wd);
      apb(1'b0, adr[i], 32'h0);
      chk("byte_rw", {24'h0, wd[7:0]}, rd);
      v[i] = wd[7:0];
    end
    apb(1'b0, pcp_pkg::ADR_ROM_ADDR, 32'h0);
    chk("rom_addr", {16'h0, v[2], v[1]}, rd);
    chk("ram_port", {16'h0, v[2], v[1]}, {16'h0, indirect_ram_port});
    chk("rom_port", {16'h0, v[2], v[1]}, {16'h0, rom_table_addr});
    apb(1'b1, 12'h100, 32'hffffffff);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, pcp_pkg::ADR_FETCH, 32'h0323);
    apb(1'b1, pcp_pkg::ADR_FETCH_LO, 32'h0028);
    apb(1'b0, pcp_pkg::ADR_FETCH, 32'h0);
    chk("fetch_lo", 32'h0328, rd);
    fp = 14'h0328;
    repeat (300) begin
      r = $random(seed);
      c = '0;
      c.op = pcp_pkg::pcp_op_t'(4'((r[31:24] % 8'd11) + 8'd1));
      c.operand_a = r[1:0] == 2'b00 ? {8{r[2]}} : r[15:8];
      c.operand_b = r[3] ? c.operand_a : r[23:16];
      c.tested_bit = r[5];
      c.target = r[4] ? 14'h3fff : r[29:16];
      c.rom_word = r[31:16];
      run_op(c);
    end
    // Mid-run reset must bring the pointer and registers back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("fp_in_reset", 32'h0, {18'h0, fetch_pointer});
    presetn <= 1'b1;
    apb(1'b0, pcp_pkg::ADR_FETCH, 32'h0);
    chk("fetch_rearm", 32'h0, rd);
    apb(1'b0, pcp_pkg::ADR_BANK, 32'h0);
    chk("bank_rearm", 32'h0, rd);
    chk("ram_port_rearm", 32'h0, {16'h0, indirect_ram_port});
    final_report();
  end
endmodule
`default_nettype wire
